// file: include/dtm_pkg.sv
/*
  Constants for the digital test output mux: register indices, field
  positions, reset values, selection codes and the bus slave states.
  Assumes a 32-bit classic Wishbone bus with byte addresses.
*/
`default_nettype none

package dtm_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 10;
  localparam int unsigned DAT_W = 32;
  localparam int unsigned SEL_W = 4;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CLOCK_DATA_SELECT = 8'h93;
  localparam logic [7:0] IDX_RX_ACTIVE_SELECT = 8'h94;
  localparam logic [7:0] IDX_SQUELCH_CONTROL = 8'h95;
  localparam logic [7:0] IDX_PIN_STATUS = 8'h96;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 9;
  localparam int unsigned SEL_LANE0 = 0;
  localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned UPPER_MSB = 7;
  localparam int unsigned UPPER_LSB = 4;
  localparam int unsigned LOWER_MSB = 3;
  localparam int unsigned LOWER_LSB = 0;
  localparam int unsigned SQUELCH_EN_BIT = 0;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic SQUELCH_RESET = 1'b0;
  localparam logic [3:0] CODE_NORMAL = 4'h0;

  // ----------------------------------------------------------------
  // Debug clock pin codes (upper nibble of 0x93)
  // ----------------------------------------------------------------
  localparam logic [3:0] CK_RECOVERED_CLOCK = 4'h1;
  localparam logic [3:0] CK_WAKE_BIT_CLOCK = 4'h2;
  localparam logic [3:0] CK_WAKE_BIT_CLOCK_X8 = 4'h3;
  localparam logic [3:0] CK_MANCHESTER_CLOCK = 4'h4;
  localparam logic [3:0] CK_ALL_ID_MATCH = 4'h5;
  localparam logic [3:0] CK_PA_ENABLE = 4'h8;
  localparam logic [3:0] CK_PRECHARGE = 4'ha;
  localparam logic [3:0] CK_DITHER_SEQUENCE = 4'hb;
  localparam logic [3:0] CK_DETECT_ENERGY = 4'hc;
  localparam logic [3:0] CK_RC_CAL_DONE = 4'hd;
  localparam logic [3:0] CK_KICKER_FAIL = 4'he;
  localparam logic [3:0] CK_CHARGE_PUMP = 4'hf;
  localparam logic [15:0] CK_VALID = 16'hfd3e;

  // ----------------------------------------------------------------
  // Debug data pin codes (lower nibble of 0x93)
  // ----------------------------------------------------------------
  localparam logic [3:0] DA_RECOVERED_DATA = 4'h1;
  localparam logic [3:0] DA_FM_SLICE = 4'h2;
  localparam logic [3:0] DA_DATA_XOR_BAUD = 4'h3;
  localparam logic [3:0] DA_DATA_INVERTED = 4'h4;
  localparam logic [3:0] DA_SNIFF_B_OVERFLOW = 4'h5;
  localparam logic [3:0] DA_KICKER_POWERDOWN = 4'h6;
  localparam logic [3:0] DA_PLL_LOCKED = 4'h7;
  localparam logic [3:0] DA_TX_ENCODED = 4'h8;
  localparam logic [3:0] DA_PACKET_OVERFLOW = 4'h9;
  localparam logic [3:0] DA_ENERGY_DWELL = 4'ha;
  localparam logic [3:0] DA_CODE_DWELL = 4'hb;
  localparam logic [3:0] DA_SNIFF_A_OVERFLOW = 4'hc;
  localparam logic [3:0] DA_BUFFER_DONE = 4'hd;
  localparam logic [3:0] DA_XTAL_POWERDOWN = 4'he;
  localparam logic [3:0] DA_BIST_BAD = 4'hf;
  localparam logic [15:0] DA_VALID = 16'hfffe;

  // ----------------------------------------------------------------
  // Receive-active pin codes (upper nibble of 0x94)
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_IN_TRANSMIT = 4'h1;
  localparam logic [3:0] RX_IN_SNIFF = 4'h2;
  localparam logic [3:0] RX_RECOVERED_DATA = 4'h3;
  localparam logic [3:0] RX_MANCHESTER_LOCK = 4'h4;
  localparam logic [3:0] RX_PATTERN_MATCH = 4'h5;
  localparam logic [3:0] RX_PLL_ACQUIRE = 4'h6;
  localparam logic [3:0] RX_ID_FOUND = 4'h7;
  localparam logic [3:0] RX_PLL_RESET = 4'h8;
  localparam logic [3:0] RX_SNIFFER_AWAKE = 4'h9;
  localparam logic [3:0] RX_RECEIVE_AWAKE = 4'ha;
  localparam logic [3:0] RX_RING_OR_SQUELCH = 4'hb;
  localparam logic [3:0] RX_ENERGY_PRESENT = 4'hc;
  localparam logic [3:0] RX_RC_CAL_FAIL = 4'hd;
  localparam logic [3:0] RX_BANDGAP_READY = 4'he;
  localparam logic [3:0] RX_BIST_DONE = 4'hf;
  localparam logic [15:0] RX_VALID = 16'hfffe;

  // ----------------------------------------------------------------
  // Bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DTM_IDLE = 2'b01,
    DTM_ACK = 2'b10
  } dtm_bus_state_type;

endpackage

`default_nettype wire

// file: include/dtm_sel_if.sv
/*
  Carrier between the register side and one output selector: the 4-bit
  code, the sixteen candidate sources, the normal-function level and the
  selected pin level. Assumes one clock shared by both ends.
*/
`default_nettype none

interface dtm_sel_if;
  logic [3:0] code;
  logic [15:0] sources;
  logic normal;
  logic pin;

  modport ctrl (output code, output sources, output normal, input pin);
  modport sel (input code, input sources, input normal, output pin);
endinterface

`default_nettype wire

// file: logic/dtm_mux16.sv
/*
  One registered 16-way output selector. Code 0 and every code not set
  in VALID_MASK give the normal-function level. Assumes synchronous
  sources in the clk_i domain.
*/
`default_nettype none

module dtm_mux16 #(
  parameter logic [15:0] VALID_MASK = 16'hfffe
) (
  input wire logic clk_i,
  input wire logic rst_i,
  dtm_sel_if.sel port
);

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  // Unassigned codes fall back to normal so a stray write never floats
  wire logic use_source;
  wire logic next_pin;
  assign use_source = (port.code != dtm_pkg::CODE_NORMAL) && VALID_MASK[port.code];
  assign next_pin = use_source ? port.sources[port.code] : port.normal;

  // Registered so the pin is glitch free between codes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port.pin <= 1'b0;
    end else begin
      port.pin <= next_pin;
    end
  end

endmodule

`default_nettype wire

// file: logic/dtm_test_mux.sv
/*
  Digital test output mux: two select registers steer internal signals
  onto the debug clock, debug data and receive-active pins. Registers are
  reached over a classic Wishbone slave. Assumes all internal signals
  are synchronous to clk_i.
*/
// The Wishbone slave port was decided locally.
// Overview of operation
// - Upper nibble of 0x93 picks debug clock pin source; code 0 is normal.
// - Lower nibble of 0x93 picks debug data pin source; code 0 is normal.
// - Upper nibble of 0x94 picks receive-active pin source; code 0 is normal.
// - With squelch enabled, code B routes squelch comparator instead of kicker ring.
// - Synthesizer dither sequence is one debug clock pin selection.
// - Code F on debug clock select shows the charge pump enable.
// - Second sniff timer overflow is a debug data source, separate from first.
`default_nettype none

module dtm_test_mux (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dtm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [dtm_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [dtm_pkg::DAT_W-1:0] wb_dat_i,
  output logic [dtm_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Normal-function levels
  input wire logic debug_clock_normal_i,
  input wire logic debug_data_normal_i,
  input wire logic receive_active_normal_i,
  // Debug clock pin sources
  input wire logic recovered_clock_i,
  input wire logic wake_bit_clock_i,
  input wire logic wake_bit_clock_x8_i,
  input wire logic manchester_clock_i,
  input wire logic all_id_match_i,
  input wire logic pa_enable_i,
  input wire logic precharge_i,
  input wire logic synth_dither_sequence_i,
  input wire logic detect_energy_i,
  input wire logic rc_cal_done_i,
  input wire logic kicker_fail_i,
  input wire logic nvm_charge_pump_enable_i,
  // Debug data pin sources
  input wire logic recovered_data_i,
  input wire logic fm_slice_data_i,
  input wire logic cdr_data_i,
  input wire logic baud_clock_i,
  input wire logic sniff_b_overflow_i,
  input wire logic kicker_powerdown_i,
  input wire logic pll_locked_i,
  input wire logic tx_data_encoded_i,
  input wire logic packet_timer_overflow_i,
  input wire logic energy_dwell_overflow_i,
  input wire logic code_dwell_overflow_i,
  input wire logic sniff_a_overflow_i,
  input wire logic buffer_done_i,
  input wire logic xtal_powerdown_i,
  input wire logic nvm_bist_bad_i,
  // Receive-active pin sources
  input wire logic in_transmit_i,
  input wire logic in_sniff_i,
  input wire logic manchester_locked_i,
  input wire logic all_pattern_match_i,
  input wire logic pll_acquire_i,
  input wire logic id_found_i,
  input wire logic pll_reset_i,
  input wire logic sniffer_awake_i,
  input wire logic receive_awake_i,
  input wire logic kicker_ring_i,
  input wire logic squelch_comparator_i,
  input wire logic energy_present_i,
  input wire logic rc_cal_fail_i,
  input wire logic bandgap_ready_i,
  input wire logic nvm_bist_done_i,
  // Pins
  output logic debug_clock_pin_o,
  output logic debug_data_pin_o,
  output logic receive_active_pin_o
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [7:0] test_mux_debug_clock_data_select;
  logic [7:0] test_mux_rx_active_select;
  logic squelch_enable;
  dtm_pkg::dtm_bus_state_type bus_state;
  dtm_pkg::dtm_bus_state_type next_bus_state;

  dtm_sel_if clock_sel ();
  dtm_sel_if data_sel ();
  dtm_sel_if rx_sel ();

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic [7:0] reg_index;
  wire logic take;
  wire logic write_lane0;
  wire logic hit_clock_data;
  wire logic hit_rx_active;
  wire logic hit_squelch;
  wire logic hit_status;
  wire logic [dtm_pkg::DAT_W-1:0] next_dat;
  wire logic [2:0] pin_state;

  assign reg_index = wb_adr_i[dtm_pkg::IDX_MSB:dtm_pkg::IDX_LSB];
  // Only one request per idle state; the ack cycle ignores the bus
  assign take = wb_cyc_i && wb_stb_i && (bus_state == dtm_pkg::DTM_IDLE);
  assign write_lane0 = take && wb_we_i && wb_sel_i[dtm_pkg::SEL_LANE0];
  assign hit_clock_data = (reg_index == dtm_pkg::IDX_CLOCK_DATA_SELECT);
  assign hit_rx_active = (reg_index == dtm_pkg::IDX_RX_ACTIVE_SELECT);
  assign hit_squelch = (reg_index == dtm_pkg::IDX_SQUELCH_CONTROL);
  assign hit_status = (reg_index == dtm_pkg::IDX_PIN_STATUS);
  assign pin_state = {receive_active_pin_o, debug_data_pin_o, debug_clock_pin_o};

  // Read mux; unmapped addresses still ack and read as zero
  assign next_dat =
    hit_clock_data ? {24'h000000, test_mux_debug_clock_data_select} :
    hit_rx_active ? {24'h000000, test_mux_rx_active_select} :
    hit_squelch ? {31'h00000000, squelch_enable} :
    hit_status ? {29'h00000000, pin_state} :
    dtm_pkg::READ_ZERO;

  // Two-state handshake: ack for exactly one cycle per request
  always_comb begin
    case (bus_state)
      dtm_pkg::DTM_IDLE: next_bus_state = take ? dtm_pkg::DTM_ACK : dtm_pkg::DTM_IDLE;
      dtm_pkg::DTM_ACK: next_bus_state = dtm_pkg::DTM_IDLE;
      default: next_bus_state = dtm_pkg::DTM_IDLE;
    endcase
  end

  // Bus state, ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= dtm_pkg::DTM_IDLE;
      wb_ack_o <= 1'b0;
      wb_dat_o <= dtm_pkg::READ_ZERO;
    end else begin
      bus_state <= next_bus_state;
      wb_ack_o <= take;
      if (take) begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // ----------------------------------------------------------------
  // Select and control registers
  // ----------------------------------------------------------------
  // Reset to code 0 so every pin powers up in its normal function
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      test_mux_debug_clock_data_select <= dtm_pkg::SELECT_RESET;
      test_mux_rx_active_select <= dtm_pkg::SELECT_RESET;
      squelch_enable <= dtm_pkg::SQUELCH_RESET;
    end else if (write_lane0) begin
      if (hit_clock_data) begin
        test_mux_debug_clock_data_select <= wb_dat_i[7:0];
      end
      if (hit_rx_active) begin
        test_mux_rx_active_select <= wb_dat_i[7:0];
      end
      if (hit_squelch) begin
        squelch_enable <= wb_dat_i[dtm_pkg::SQUELCH_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Source packing
  // ----------------------------------------------------------------
  // Select nibbles to the three selectors
  assign clock_sel.code = test_mux_debug_clock_data_select[dtm_pkg::UPPER_MSB:dtm_pkg::UPPER_LSB];
  assign data_sel.code = test_mux_debug_clock_data_select[dtm_pkg::LOWER_MSB:dtm_pkg::LOWER_LSB];
  assign rx_sel.code = test_mux_rx_active_select[dtm_pkg::UPPER_MSB:dtm_pkg::UPPER_LSB];
  // Lower nibble of 0x94 is stored but drives no pin
  assign clock_sel.normal = debug_clock_normal_i;
  assign data_sel.normal = debug_data_normal_i;
  assign rx_sel.normal = receive_active_normal_i;

  // Debug clock pin candidates
  always_comb begin
    clock_sel.sources = 16'h0000;
    clock_sel.sources[dtm_pkg::CK_RECOVERED_CLOCK] = recovered_clock_i;
    clock_sel.sources[dtm_pkg::CK_WAKE_BIT_CLOCK] = wake_bit_clock_i;
    clock_sel.sources[dtm_pkg::CK_WAKE_BIT_CLOCK_X8] = wake_bit_clock_x8_i;
    clock_sel.sources[dtm_pkg::CK_MANCHESTER_CLOCK] = manchester_clock_i;
    clock_sel.sources[dtm_pkg::CK_ALL_ID_MATCH] = all_id_match_i;
    clock_sel.sources[dtm_pkg::CK_PA_ENABLE] = pa_enable_i;
    clock_sel.sources[dtm_pkg::CK_PRECHARGE] = precharge_i;
    clock_sel.sources[dtm_pkg::CK_DITHER_SEQUENCE] = synth_dither_sequence_i;
    clock_sel.sources[dtm_pkg::CK_DETECT_ENERGY] = detect_energy_i;
    clock_sel.sources[dtm_pkg::CK_RC_CAL_DONE] = rc_cal_done_i;
    clock_sel.sources[dtm_pkg::CK_KICKER_FAIL] = kicker_fail_i;
    clock_sel.sources[dtm_pkg::CK_CHARGE_PUMP] = nvm_charge_pump_enable_i;
  end

  // Debug data pin candidates
  always_comb begin
    data_sel.sources = 16'h0000;
    data_sel.sources[dtm_pkg::DA_RECOVERED_DATA] = recovered_data_i;
    data_sel.sources[dtm_pkg::DA_FM_SLICE] = fm_slice_data_i;
    data_sel.sources[dtm_pkg::DA_DATA_XOR_BAUD] = cdr_data_i ^ baud_clock_i;
    data_sel.sources[dtm_pkg::DA_DATA_INVERTED] = ~cdr_data_i;
    data_sel.sources[dtm_pkg::DA_SNIFF_B_OVERFLOW] = sniff_b_overflow_i;
    data_sel.sources[dtm_pkg::DA_KICKER_POWERDOWN] = kicker_powerdown_i;
    data_sel.sources[dtm_pkg::DA_PLL_LOCKED] = pll_locked_i;
    data_sel.sources[dtm_pkg::DA_TX_ENCODED] = tx_data_encoded_i;
    data_sel.sources[dtm_pkg::DA_PACKET_OVERFLOW] = packet_timer_overflow_i;
    data_sel.sources[dtm_pkg::DA_ENERGY_DWELL] = energy_dwell_overflow_i;
    data_sel.sources[dtm_pkg::DA_CODE_DWELL] = code_dwell_overflow_i;
    data_sel.sources[dtm_pkg::DA_SNIFF_A_OVERFLOW] = sniff_a_overflow_i;
    data_sel.sources[dtm_pkg::DA_BUFFER_DONE] = buffer_done_i;
    data_sel.sources[dtm_pkg::DA_XTAL_POWERDOWN] = xtal_powerdown_i;
    data_sel.sources[dtm_pkg::DA_BIST_BAD] = nvm_bist_bad_i;
  end

  // Receive-active pin candidates
  always_comb begin
    rx_sel.sources = 16'h0000;
    rx_sel.sources[dtm_pkg::RX_IN_TRANSMIT] = in_transmit_i;
    rx_sel.sources[dtm_pkg::RX_IN_SNIFF] = in_sniff_i;
    rx_sel.sources[dtm_pkg::RX_RECOVERED_DATA] = recovered_data_i;
    rx_sel.sources[dtm_pkg::RX_MANCHESTER_LOCK] = manchester_locked_i;
    rx_sel.sources[dtm_pkg::RX_PATTERN_MATCH] = all_pattern_match_i;
    rx_sel.sources[dtm_pkg::RX_PLL_ACQUIRE] = pll_acquire_i;
    rx_sel.sources[dtm_pkg::RX_ID_FOUND] = id_found_i;
    rx_sel.sources[dtm_pkg::RX_PLL_RESET] = pll_reset_i;
    rx_sel.sources[dtm_pkg::RX_SNIFFER_AWAKE] = sniffer_awake_i;
    rx_sel.sources[dtm_pkg::RX_RECEIVE_AWAKE] = receive_awake_i;
    // Shared code: squelch comparator replaces the kicker ring when squelch is enabled
    rx_sel.sources[dtm_pkg::RX_RING_OR_SQUELCH] =
      squelch_enable ? squelch_comparator_i : kicker_ring_i;
    rx_sel.sources[dtm_pkg::RX_ENERGY_PRESENT] = energy_present_i;
    rx_sel.sources[dtm_pkg::RX_RC_CAL_FAIL] = rc_cal_fail_i;
    rx_sel.sources[dtm_pkg::RX_BANDGAP_READY] = bandgap_ready_i;
    rx_sel.sources[dtm_pkg::RX_BIST_DONE] = nvm_bist_done_i;
  end

  // ----------------------------------------------------------------
  // Output selectors
  // ----------------------------------------------------------------
  // Valid masks send empty codes to the normal function
  dtm_mux16 #(.VALID_MASK(dtm_pkg::CK_VALID)) u_clock_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port(clock_sel)
  );

  dtm_mux16 #(.VALID_MASK(dtm_pkg::DA_VALID)) u_data_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port(data_sel)
  );

  dtm_mux16 #(.VALID_MASK(dtm_pkg::RX_VALID)) u_rx_mux (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .port(rx_sel)
  );

  // Pins come straight from the selector flip-flops
  assign debug_clock_pin_o = clock_sel.pin;
  assign debug_data_pin_o = data_sel.pin;
  assign receive_active_pin_o = rx_sel.pin;

endmodule

`default_nettype wire

// file: sim/dtm_pin_probe.sv
/*
  Bench instrument on the three debug pins: shows the levels it sees
  and counts cycles in which any pin changes level. Assumes pins are synchronous to clk_i.
*/
`default_nettype none

module dtm_pin_probe (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] pins_i,
  output logic [2:0] seen_o,
  output logic [7:0] toggles_o
);
  logic [2:0] last;

  // Direct sense; a scope adds no delay worth modelling
  assign seen_o = pins_i;

  // Activity count, saturating so a long run cannot wrap to zero
  always @(posedge clk_i) begin
    last <= pins_i;
    if (rst_i) begin
      toggles_o <= 8'h00;
    end else if (last != pins_i && toggles_o != 8'hff) begin
      toggles_o <= toggles_o + 8'h01;
    end
  end
endmodule

`default_nettype wire

// file: sim/dtm_test_mux_props.sv
/*
  Checker for the test output mux: bus handshake and pin selection.
  Assumes it sees only the top module ports, bound by name.
*/
`default_nettype none

module dtm_test_mux_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [dtm_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [dtm_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [dtm_pkg::DAT_W-1:0] wb_dat_i,
  input wire logic [dtm_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic debug_clock_normal_i,
  input wire logic debug_data_normal_i,
  input wire logic receive_active_normal_i,
  input wire logic synth_dither_sequence_i,
  input wire logic nvm_charge_pump_enable_i,
  input wire logic sniff_a_overflow_i,
  input wire logic sniff_b_overflow_i,
  input wire logic kicker_ring_i,
  input wire logic squelch_comparator_i,
  input wire logic debug_clock_pin_o,
  input wire logic debug_data_pin_o,
  input wire logic receive_active_pin_o
);
  logic [7:0] sh_cd;
  logic [7:0] sh_rx;
  logic sh_sq;

  // ------------------------------------------------------------
  // Shadow of the select registers, from bus writes
  // ------------------------------------------------------------
  wire logic take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr0 = take & wb_we_i & wb_sel_i[0];
  wire logic [7:0] idx = wb_adr_i[9:2];

  // Updated at the taking edge, same edge the design stores
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_cd <= 8'h00;
      sh_rx <= 8'h00;
      sh_sq <= 1'b0;
    end else begin
      if (wr0 && idx == 8'h93) sh_cd <= wb_dat_i[7:0];
      if (wr0 && idx == 8'h94) sh_rx <= wb_dat_i[7:0];
      if (wr0 && idx == 8'h95) sh_sq <= wb_dat_i[0];
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  AST_ACK_AFTER_REQ: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_HOLD: assert property (!take |=> $stable(wb_dat_o))
    else $error("read data changed without request");
  AST_RD_SELECT: assert property (
    (take && !wb_we_i && idx == 8'h93) |=> wb_dat_o == {24'h0, $past(sh_cd)})
    else $error("select readback wrong");
  AST_RESET_PINS: assert property (disable iff (1'b0)
    rst_i |=> {debug_clock_pin_o, debug_data_pin_o, receive_active_pin_o} == 3'b000)
    else $error("pins not low in reset");
  AST_CK_NORMAL: assert property (
    (sh_cd[7:4] inside {4'h0, 4'h6, 4'h7, 4'h9}) |=>
    debug_clock_pin_o == $past(debug_clock_normal_i))
    else $error("clock pin not normal");
  AST_CK_DITHER: assert property (
    (sh_cd[7:4] == 4'hb) |=> debug_clock_pin_o == $past(synth_dither_sequence_i))
    else $error("clock pin not dither");
  AST_CK_PUMP: assert property (
    (sh_cd[7:4] == 4'hf) |=> debug_clock_pin_o == $past(nvm_charge_pump_enable_i))
    else $error("clock pin not pump enable");
  AST_DA_NORMAL: assert property (
    (sh_cd[3:0] == 4'h0) |=> debug_data_pin_o == $past(debug_data_normal_i))
    else $error("data pin not normal");
  AST_DA_SNIFF: assert property (
    (sh_cd[3:0] == 4'h5 || sh_cd[3:0] == 4'hc) |=> debug_data_pin_o ==
    $past(sh_cd[3:0] == 4'h5 ? sniff_b_overflow_i : sniff_a_overflow_i))
    else $error("data pin sniff overflow wrong");
  AST_RX_NORMAL: assert property (
    (sh_rx[7:4] == 4'h0) |=> receive_active_pin_o == $past(receive_active_normal_i))
    else $error("rx pin not normal");
  AST_RX_RING: assert property (
    (sh_rx[7:4] == 4'hb) |=> receive_active_pin_o ==
    $past(sh_sq ? squelch_comparator_i : kicker_ring_i))
    else $error("rx pin ring or squelch wrong");
endmodule

bind dtm_test_mux dtm_test_mux_props u_dtm_test_mux_props (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .debug_clock_normal_i, .debug_data_normal_i, .receive_active_normal_i,
  .synth_dither_sequence_i, .nvm_charge_pump_enable_i, .sniff_a_overflow_i,
  .sniff_b_overflow_i, .kicker_ring_i, .squelch_comparator_i, .debug_clock_pin_o,
  .debug_data_pin_o, .receive_active_pin_o);

`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench for the test output mux: random sources, every
  select code, squelch on and off, bus corner cases and a second reset.
  Assumes the checker is bound separately.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [15:0] ck = 16'h0000, da = 16'h0000, rx = 16'h0000;
  logic [2:0] pins, seen;
  logic [7:0] tog;
  logic [7:0] m93 = 8'h00, m94 = 8'h00;
  logic sq = 1'b0;
  int seed = 36;
  int fail_count = 0;
  int n_tests = 0;
  logic [2:0] pq[$];
  logic [31:0] rq[$];

  initial forever #25 clk_i = ~clk_i;

  dtm_test_mux u_dtm_test_mux (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .debug_clock_normal_i(ck[0]), .debug_data_normal_i(da[0]),
    .receive_active_normal_i(rx[0]), .recovered_clock_i(ck[1]), .wake_bit_clock_i(ck[2]),
    .wake_bit_clock_x8_i(ck[3]), .manchester_clock_i(ck[4]), .all_id_match_i(ck[5]),
    .pa_enable_i(ck[8]), .precharge_i(ck[10]), .synth_dither_sequence_i(ck[11]),
    .detect_energy_i(ck[12]), .rc_cal_done_i(ck[13]), .kicker_fail_i(ck[14]),
    .nvm_charge_pump_enable_i(ck[15]), .recovered_data_i(da[1]), .fm_slice_data_i(da[2]),
    .cdr_data_i(da[3]), .baud_clock_i(da[4]), .sniff_b_overflow_i(da[5]),
    .kicker_powerdown_i(da[6]), .pll_locked_i(da[7]), .tx_data_encoded_i(da[8]),
    .packet_timer_overflow_i(da[9]), .energy_dwell_overflow_i(da[10]),
    .code_dwell_overflow_i(da[11]), .sniff_a_overflow_i(da[12]), .buffer_done_i(da[13]),
    .xtal_powerdown_i(da[14]), .nvm_bist_bad_i(da[15]), .in_transmit_i(rx[1]),
    .in_sniff_i(rx[2]), .squelch_comparator_i(rx[3]), .manchester_locked_i(rx[4]),
    .all_pattern_match_i(rx[5]), .pll_acquire_i(rx[6]), .id_found_i(rx[7]),
    .pll_reset_i(rx[8]), .sniffer_awake_i(rx[9]), .receive_awake_i(rx[10]),
    .kicker_ring_i(rx[11]), .energy_present_i(rx[12]), .rc_cal_fail_i(rx[13]),
    .bandgap_ready_i(rx[14]), .nvm_bist_done_i(rx[15]), .debug_clock_pin_o(pins[0]),
    .debug_data_pin_o(pins[1]), .receive_active_pin_o(pins[2]));

  dtm_pin_probe u_dtm_pin_probe (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
    .seen_o(seen), .toggles_o(tog));

  // ------------------------------------------------------------
  // Expected pin levels; unassigned codes fall back to normal
  // ------------------------------------------------------------
  function automatic logic e_ck(input logic [3:0] c);
    return (c != 4'h0 && dtm_pkg::CK_VALID[c]) ? ck[c] : ck[0];
  endfunction
  function automatic logic e_da(input logic [3:0] c);
    return (c == 4'h3) ? da[3] ^ da[4] : (c == 4'h4) ? ~da[3] : da[c];
  endfunction
  // Code 3 shares recovered data with the data pin
  function automatic logic e_rx(input logic [3:0] c);
    return (c == 4'h3) ? da[1] : (c == 4'hb) ? (sq ? rx[3] : rx[11]) : rx[c];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", fail_count, n_tests);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      fail_count++;
      wrap_up();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [3:0] s);
    wb(1'b1, a, {24'h0, d}, s);
    if (s[0] && a == 10'h24c) m93 = d;
    if (s[0] && a == 10'h250) m94 = d;
    if (s[0] && a == 10'h254) sq = d[0];
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    rq.push_back({24'h0, e});
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  // Note what this edge captures, then launch new random sources
  task automatic run_pins(input int n);
    logic [63:0] rr;
    repeat (n) begin
      @(posedge clk_i);
      pq.push_back({e_rx(m94[7:4]), e_da(m93[3:0]), e_ck(m93[7:4])});
      rr = {$random(seed), $random(seed)};
      {ck, da, rx} <= rr[47:0];
    end
  endtask

  // ------------------------------------------------------------
  // Result watcher: oldest note against what appears
  // ------------------------------------------------------------
  always @(negedge clk_i) begin
    if (pq.size() > 0) chk("pins", {29'h0, pq.pop_front()}, {29'h0, seen});
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0) chk("read", rq.pop_front(), rdat);
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(10'h24c, 8'h00);
    rd(10'h250, 8'h00);
    run_pins(4);
    for (int c = 0; c < 16; c++) begin
      wr(10'h24c, {c[3:0], ~c[3:0]}, 4'h1);
      rd(10'h24c, {c[3:0], ~c[3:0]});
      run_pins(8);
    end
    for (int s = 0; s < 2; s++) begin
      wr(10'h254, {7'h00, s[0]}, 4'h1);
      for (int c = 0; c < 16; c++) begin
        wr(10'h250, {c[3:0], 4'h9 ^ c[3:0]}, 4'h1);
        run_pins(8);
      end
    end
    // Low byte lane off: write must not land
    wr(10'h24c, 8'h5a, 4'he);
    rd(10'h24c, m93);
    wr(10'h3fc, 8'hff, 4'h1);
    rd(10'h3fc, 8'h00);
    run_pins(4);
    // Second reset in mid-run clears the selects
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    m93 = 8'h00;
    m94 = 8'h00;
    sq = 1'b0;
    rd(10'h24c, 8'h00);
    rd(10'h254, 8'h00);
    run_pins(4);
    chk("activity", 32'h1, {31'h0, |tog});
    wrap_up();
  end
endmodule

`default_nettype wire
